// file: power_mgmt_defs.svh
// Functional notes
// - Host-initiated resumes leave every wake enable bit untouched.
// - Ready flag is read-only and reads zero after reset.
// - Ready stays low until PHY reset completes and the PHY is operational.
// - Ready stays low while configuration content loads from nonvolatile store.
// - Two-bit read/write sleep state select, reset value 10b.
// - Select codes 00, 01, 10, 11 pick sleep states zero to three.
// - Entering the unconfigured normal state reverts the select to 10b.
// - Sleep states zero and one act alike; both codes stay selectable.
// - Writing one to the self-clearing request resets the PHY at least 4 ms.
// - The request bit clears itself when the PHY leaves reset; resets to 0.
// - Writes to the request bit are ignored while it reads high.
// - Setting the request bit clears the ready flag at once.
// - After a requested PHY reset, ready returns once the PHY is operational.
// - Without the skip analog reference wait bit, the hold stretches to 128 ms.
// - LAN wake enable, read/write, reset 0, arms wake-on-LAN as wake source.
// - PHY interrupt wake enable, read/write, reset 0, arms the PHY interrupt.
// - With the resume-clears control set, resume completion clears both enables.
// - Resume-clears control resets to 1 and acts only on remote-wake resumes.
`ifndef POWER_MGMT_DEFS_SVH
`define POWER_MGMT_DEFS_SVH

`define PM_CTRL_OFS        4'h0
`define PM_BIT_PHY_IRQ_WE  2
`define PM_BIT_LAN_WE      3
`define PM_BIT_PHY_RESET_REQUEST_REQ 4
`define PM_BIT_SLEEP_LO    5
`define PM_BIT_SLEEP_HI    6
`define PM_BIT_READY       7
`define PM_BIT_RES_CLR_WE  8
`define PM_BIT_SKIP_REF    15
`define PM_SLEEP_RESET     2'h2
`define PM_RES_CLR_RESET   1'h1
`define PM_SKIP_REF_RESET  1'h0
`define PM_CLK_KHZ         125000
`define PM_PHY_RESET_REQUEST_MIN_MS  4
`define PM_PHY_RESET_REQUEST_EXT_MS  128
`define PM_PHY_RESET_REQUEST_MIN_CYC (`PM_PHY_RESET_REQUEST_MIN_MS * `PM_CLK_KHZ)
`define PM_PHY_RESET_REQUEST_EXT_CYC (`PM_PHY_RESET_REQUEST_EXT_MS * `PM_CLK_KHZ)

`endif

// file: power_mgmt_pkg.sv
package power_mgmt_pkg;

	typedef enum logic [2:0] {
		PHY_HOLD    = 3'b001,
		PHY_WAIT_OP = 3'b010,
		PHY_RUN     = 3'b100
	} phy_state_type;

	typedef enum logic [1:0] {
		SLEEP_STATE_ZERO  = 2'h0,
		SLEEP_STATE_ONE   = 2'h1,
		SLEEP_STATE_TWO   = 2'h2,
		SLEEP_STATE_THREE = 2'h3
	} sleep_state_type;

endpackage

// file: power_mgmt_ready_phy_reset.sv
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "power_mgmt_defs.svh"

module power_mgmt_ready_phy_reset #(
	parameter int unsigned ADDR_W         = 4,
	parameter int unsigned HOLD_SHORT_CYC = `PM_PHY_RESET_REQUEST_MIN_CYC,
	parameter int unsigned HOLD_LONG_CYC  = `PM_PHY_RESET_REQUEST_EXT_CYC
) (
	input  wire logic                            i_clk,
	input  wire logic                            i_reset_n,
	input  wire logic [ADDR_W-1:0]               i_avs_address,
	input  wire logic                            i_avs_read,
	input  wire logic                            i_avs_write,
	input  wire logic [31:0]                     i_avs_writedata,
	input  wire logic [3:0]                      i_avs_byteenable,
	output logic [31:0]                          o_avs_readdata,
	output logic                                 o_avs_waitrequest,
	input  wire logic                            i_phy_operational,
	input  wire logic                            i_config_loading,
	input  wire logic                            i_enter_unconfigured,
	input  wire logic                            i_resume_done,
	input  wire logic                            i_resume_remote,
	output logic                                 o_phy_reset_n,
	output logic                                 o_ready,
	output power_mgmt_pkg::sleep_state_type      o_sleep_state,
	output logic [1:0]                           o_sleep_select,
	output logic                                 o_lan_wake_enable,
	output logic                                 o_phy_irq_wake_enable
);
	import power_mgmt_pkg::*;

	localparam int unsigned CNT_W = 24;

	// Sleep zero and sleep one share one power behaviour, so the code
	// driven to the power controller folds one onto zero while software
	// still reads back whatever it wrote.
	function automatic sleep_state_type effective_sleep(
		input logic [1:0] sel
	);
		case (sel)
			2'h0:    effective_sleep = SLEEP_STATE_ZERO;
			2'h1:    effective_sleep = SLEEP_STATE_ZERO;
			2'h2:    effective_sleep = SLEEP_STATE_TWO;
			2'h3:    effective_sleep = SLEEP_STATE_THREE;
			default: effective_sleep = SLEEP_STATE_TWO;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] hold_length(input logic skip);
		hold_length = skip ? CNT_W'(HOLD_SHORT_CYC) : CNT_W'(HOLD_LONG_CYC);
	endfunction

	logic                rst_meta_r;
	logic                rst_sync_r;
	logic                rst_n;
	logic                op_meta_r;
	logic                op_sync_r;
	logic                ack_r;
	logic [31:0]         rdata_r;
	phy_state_type       phy_state_r;
	phy_state_type       phy_state_nxt;
	logic [CNT_W-1:0]    hold_cnt_r;
	logic [CNT_W-1:0]    hold_cnt_nxt;
	logic [1:0]          sleep_sel_r;
	logic [1:0]          sleep_sel_nxt;
	logic                lan_we_r;
	logic                lan_we_nxt;
	logic                irq_we_r;
	logic                irq_we_nxt;
	logic                res_clr_r;
	logic                skip_ref_r;
	logic                ready_r;
	logic                ready_nxt;
	logic                req_flag_r;
	sleep_state_type     sleep_state_r;

	wire                 req_active  = i_avs_read | i_avs_write;
	wire                 hit         = i_avs_address ==
	                                   ADDR_W'(`PM_CTRL_OFS);
	wire                 wr_acc      = i_avs_write & ack_r & hit;
	wire                 lane0       = wr_acc & i_avs_byteenable[0];
	wire                 lane1       = wr_acc & i_avs_byteenable[1];
	wire                 req_bit     = phy_state_r == PHY_HOLD;
	wire                 hold_done   = req_bit & (hold_cnt_r == CNT_W'(1));
	wire                 start_reset = lane0 & ~req_flag_r &
	                                   i_avs_writedata[`PM_BIT_PHY_RESET_REQUEST_REQ];
	wire                 skip_new    = lane1 ?
	                                   i_avs_writedata[`PM_BIT_SKIP_REF] :
	                                   skip_ref_r;
	wire                 remote_clr  = i_resume_done & i_resume_remote &
	                                   res_clr_r;
	wire [31:0]          ctrl_word   = {16'h0000,
	                                    skip_ref_r,
	                                    6'h00,
	                                    res_clr_r,
	                                    ready_r,
	                                    sleep_sel_r,
	                                    req_flag_r,
	                                    lan_we_r,
	                                    irq_we_r,
	                                    2'h0};

	assign rst_n                 = rst_sync_r;
	assign o_avs_waitrequest     = req_active & ~ack_r;
	assign o_avs_readdata        = rdata_r;
	assign o_phy_reset_n         = ~req_bit;
	assign o_ready               = ready_r;
	assign o_sleep_select        = sleep_sel_r;
	assign o_sleep_state         = sleep_state_r;
	assign o_lan_wake_enable     = lan_we_r;
	assign o_phy_irq_wake_enable = irq_we_r;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// The PHY reports readiness from its own timing, so it is synchronised.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_meta_r <= 1'b0;
			op_sync_r <= 1'b0;
		end else begin
			op_meta_r <= i_phy_operational;
			op_sync_r <= op_meta_r;
		end
	end

	// One wait state: read data is captured in the first cycle of a
	// request and stands while waitrequest is low in the second.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req_active & ~ack_r;
			if (i_avs_read & ~ack_r) begin
				rdata_r <= hit ? ctrl_word : 32'h0000_0000;
			end
		end
	end

	// The PHY is reset from power-up so that ready only rises once it runs.
	always_comb begin
		phy_state_nxt = phy_state_r;
		hold_cnt_nxt  = hold_cnt_r;
		case (phy_state_r)
			PHY_HOLD: begin
				hold_cnt_nxt = hold_cnt_r - CNT_W'(1);
				if (hold_done) begin
					phy_state_nxt = PHY_WAIT_OP;
				end
			end
			PHY_WAIT_OP: begin
				if (op_sync_r) begin
					phy_state_nxt = PHY_RUN;
				end
			end
			PHY_RUN: begin
			end
			default: begin
				phy_state_nxt = PHY_HOLD;
			end
		endcase
		if (start_reset) begin
			phy_state_nxt = PHY_HOLD;
			hold_cnt_nxt  = hold_length(skip_new);
		end
	end

	// Ready is also gated by start_reset, decoded straight from the bus write,
	// so a request arriving in the same cycle pulls it low at the next edge.
	always_comb begin
		ready_nxt = (phy_state_r == PHY_RUN) & op_sync_r &
		            ~i_config_loading & ~start_reset;
		if (start_reset) begin
			ready_nxt = 1'b0;
		end
	end

	always_comb begin
		sleep_sel_nxt = sleep_sel_r;
		if (lane0) begin
			sleep_sel_nxt = i_avs_writedata[`PM_BIT_SLEEP_HI:
			                                `PM_BIT_SLEEP_LO];
		end
		if (i_enter_unconfigured) begin
			sleep_sel_nxt = `PM_SLEEP_RESET;
		end
	end

	// A software write in the same cycle as a remote-wake clear wins, so a
	// fresh enable is never lost to a resume that was already finishing.
	always_comb begin
		lan_we_nxt = lan_we_r;
		irq_we_nxt = irq_we_r;
		if (remote_clr) begin
			lan_we_nxt = 1'b0;
			irq_we_nxt = 1'b0;
		end
		if (lane0) begin
			lan_we_nxt = i_avs_writedata[`PM_BIT_LAN_WE];
			irq_we_nxt = i_avs_writedata[`PM_BIT_PHY_IRQ_WE];
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_state_r <= PHY_HOLD;
			// The skip bit resets to zero, so the power-up hold is long.
			hold_cnt_r  <= CNT_W'(HOLD_LONG_CYC);
			ready_r     <= 1'b0;
			sleep_sel_r <= `PM_SLEEP_RESET;
			sleep_state_r <= SLEEP_STATE_TWO;
			lan_we_r    <= 1'b0;
			irq_we_r    <= 1'b0;
		end else begin
			phy_state_r <= phy_state_nxt;
			hold_cnt_r  <= hold_cnt_nxt;
			ready_r     <= ready_nxt;
			sleep_sel_r <= sleep_sel_nxt;
			sleep_state_r <= effective_sleep(sleep_sel_nxt);
			lan_we_r    <= lan_we_nxt;
			irq_we_r    <= irq_we_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			res_clr_r  <= `PM_RES_CLR_RESET;
			skip_ref_r <= `PM_SKIP_REF_RESET;
		end else if (lane1) begin
			res_clr_r  <= i_avs_writedata[`PM_BIT_RES_CLR_WE];
			skip_ref_r <= i_avs_writedata[`PM_BIT_SKIP_REF];
		end
	end

	// The request bit tracks software requests only, so it reads zero while
	// the power-up hold runs; a write of one then restarts the hold.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_flag_r <= 1'b0;
		end else if (start_reset) begin
			req_flag_r <= 1'b1;
		end else if (hold_done) begin
			req_flag_r <= 1'b0;
		end
	end

	// Counts how long the PHY reset output has been low.
	logic [CNT_W-1:0] low_len_r;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_len_r <= CNT_W'(1);
		end else if (o_phy_reset_n) begin
			low_len_r <= '0;
		end else if (low_len_r != '1) begin
			low_len_r <= low_len_r + CNT_W'(1);
		end
	end

	a_hold_min_len: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		$rose(o_phy_reset_n) |-> low_len_r >= CNT_W'(HOLD_SHORT_CYC))
		else $error("PHY reset released before the minimum hold");

	a_hold_len_select: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		start_reset |=> hold_cnt_r == (skip_ref_r ?
		                CNT_W'(HOLD_SHORT_CYC) : CNT_W'(HOLD_LONG_CYC)))
		else $error("PHY reset hold length does not follow skip bit");

	a_req_self_clear: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		hold_done && !start_reset |=> !req_flag_r && o_phy_reset_n)
		else $error("Reset request bit did not clear on release");

	a_req_write_ignored: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		req_flag_r && !hold_done && wr_acc |=>
		req_flag_r && hold_cnt_r == $past(hold_cnt_r) - CNT_W'(1))
		else $error("Write disturbed a running PHY reset");

	a_ready_drop_now: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		start_reset |=> !o_ready ##1 !o_ready)
		else $error("Ready did not clear on a PHY reset request");

	a_ready_cause: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		$rose(o_ready) |-> $past(phy_state_r) == PHY_RUN &&
		!$past(i_config_loading) && $past(op_sync_r))
		else $error("Ready rose while PHY or configuration was busy");

	a_ready_returns: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		phy_state_r == PHY_RUN && op_sync_r && !i_config_loading &&
		!start_reset |=> o_ready)
		else $error("Ready did not return with an operational PHY");

	a_unconf_revert: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		i_enter_unconfigured |=> o_sleep_select == `PM_SLEEP_RESET
		                         ##0 o_sleep_state == SLEEP_STATE_TWO)
		else $error("Sleep select did not revert on unconfiguration");

	a_host_resume_keep: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		i_resume_done && !i_resume_remote && !lane0 |=>
		$stable(lan_we_r) && $stable(irq_we_r))
		else $error("Host resume changed a wake enable");

	a_remote_resume_clr: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		remote_clr && !lane0 |=>
		!o_lan_wake_enable && !o_phy_irq_wake_enable)
		else $error("Remote resume left a wake enable set");

	a_sleep_fold: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		o_sleep_select == 2'h1 |-> o_sleep_state == SLEEP_STATE_ZERO)
		else $error("Sleep code one differs from sleep code zero");

	a_bus_one_wait: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		req_active && !ack_r |-> o_avs_waitrequest ##1
		(!req_active || !o_avs_waitrequest))
		else $error("Bus answer not given after one wait state");

	a_req_flag_hold: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		req_flag_r |-> !o_phy_reset_n)
		else $error("Reset request bit high with the PHY released");

	a_ready_low_hold: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		!o_phy_reset_n |=> !o_ready)
		else $error("Ready high while the PHY is held in reset");

	a_wake_write: assert property (
		@(posedge i_clk) disable iff (!rst_n)
		lane0 |=> o_lan_wake_enable ==
		$past(i_avs_writedata[`PM_BIT_LAN_WE]) && o_phy_irq_wake_enable ==
		$past(i_avs_writedata[`PM_BIT_PHY_IRQ_WE]))
		else $error("Wake enable did not take the written value");

endmodule

// file: phy_model.sv
`timescale 1ns/100ps

module phy_model #(
	parameter int OP_DLY = 6
) (
	input  wire logic i_clk,
	input  wire logic i_phy_reset_n,
	output logic      o_operational
);
	int cnt_r;

	// Operational comes some cycles after release, never at the release edge.
	always_ff @(posedge i_clk) begin
		if (!i_phy_reset_n) begin
			cnt_r <= 0;
			o_operational <= 1'b0;
		end else if (cnt_r < OP_DLY) begin
			cnt_r <= cnt_r + 1;
		end else begin
			o_operational <= 1'b1;
		end
	end
endmodule

// file: tb.sv
`timescale 1ns/100ps

module tb;
	import power_mgmt_pkg::*;
	localparam int SH = 20;
	localparam int LH = 40;
	logic clk = 0, reset_n = 0, rd = 0, wr = 0, cfg = 0, uncfg = 0;
	logic rdone = 0, rremote = 0, wreq, op, prst_n, ready, lan_we, irq_we;
	logic [3:0] adr = 4'h0, be = 4'hf;
	logic [31:0] wdat = 32'h0000_0000, rdat, q;
	logic [1:0] ssel;
	sleep_state_type sstate;
	int errors = 0, checks = 0, low_n = 0, hold = 0;

	power_mgmt_ready_phy_reset #(
		.HOLD_SHORT_CYC (SH),
		.HOLD_LONG_CYC  (LH)
	) DUT (
		.i_clk (clk), .i_reset_n (reset_n), .i_avs_address (adr),
		.i_avs_read (rd), .i_avs_write (wr), .i_avs_writedata (wdat),
		.i_avs_byteenable (be), .o_avs_readdata (rdat),
		.o_avs_waitrequest (wreq), .i_phy_operational (op),
		.i_config_loading (cfg), .i_enter_unconfigured (uncfg),
		.i_resume_done (rdone), .i_resume_remote (rremote),
		.o_phy_reset_n (prst_n), .o_ready (ready), .o_sleep_state (sstate),
		.o_sleep_select (ssel), .o_lan_wake_enable (lan_we),
		.o_phy_irq_wake_enable (irq_we)
	);

	phy_model phy (.i_clk (clk), .i_phy_reset_n (prst_n), .o_operational (op));

	always #4 clk = ~clk;

	// Length of the last PHY reset pulse, in cycles.
	always @(posedge clk) begin
		if (prst_n === 1'b0) begin
			low_n <= low_n + 1;
		end else begin
			if (low_n != 0) hold <= low_n;
			low_n <= 0;
		end
	end

	task automatic report_and_stop;
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask

	// The request stays put until waitrequest is seen low at an edge.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wait_hi(input logic sel);
		int n;
		n = 0;
		while ((sel ? ready : prst_n) !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200) begin
			errors++;
		end
	endtask

	task automatic resume(input logic r);
		@(posedge clk);
		rdone <= 1'b1;
		rremote <= r;
		@(posedge clk);
		rdone <= 1'b0;
		@(negedge clk);
	endtask

	task automatic phy_pulse(input logic [31:0] d, input int exp_hold);
		bus(1, 4'h0, d);
		@(negedge clk);
		chk("ready", ready, 0);
		chk("phy_reset_request", prst_n, 0);
		bus(0, 4'h0, 0);
		chk("ctrl", q, d);
		bus(1, 4'h0, d);
		wait_hi(0);
		@(negedge clk);
		chk("hold", hold, exp_hold);
		bus(0, 4'h0, 0);
		chk("ctrl", q, d & 32'hffff_ffef);
		wait_hi(1);
		chk("ready", ready, 1);
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		report_and_stop;
	end

	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk("ready", ready, 0);
		chk("phy_reset_request", prst_n, 0);
		wait_hi(1);
		chk("ready", ready, 1);
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_01c0);
		bus(1, 4'h0, 32'hffff_006c);
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_00ec);
		for (int i = 0; i < 4; i++) begin
			bus(1, 4'h0, 32'h0000_0100 | (i << 5));
			@(negedge clk);
			chk("sel", ssel, i);
			chk("state", sstate, (i == 1) ? 0 : i);
		end
		@(posedge clk);
		uncfg <= 1'b1;
		@(posedge clk);
		uncfg <= 1'b0;
		@(negedge clk);
		chk("sel", ssel, 2);
		chk("state", sstate, 2);
		// From here on sleep state two is programmed, except by the 32'h0000_806c write, which selects three.
		bus(1, 4'h0, 32'h0000_014c);
		resume(0);
		chk("wake", {lan_we, irq_we}, 2'b11);
		resume(1);
		chk("wake", {lan_we, irq_we}, 2'b00);
		bus(1, 4'h0, 32'h0000_004c);
		resume(1);
		chk("wake", {lan_we, irq_we}, 2'b11);
		be <= 4'h1;
		bus(1, 4'h0, 32'h0000_8140);
		be <= 4'hf;
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_00c0);
		bus(1, 4'h4, 32'hffff_ffff);
		bus(0, 4'h4, 0);
		chk("unmapped", q, 0);
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_00c0);
		resume(0);
		phy_pulse(32'h0000_8150, SH);
		phy_pulse(32'h0000_0150, LH);
		@(posedge clk);
		cfg <= 1'b1;
		repeat (3) @(negedge clk);
		chk("ready", ready, 0);
		@(posedge clk);
		cfg <= 1'b0;
		wait_hi(1);
		chk("ready", ready, 1);
		bus(1, 4'h0, 32'h0000_806c);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_0140);
		bus(1, 4'h0, 32'h0000_01c0);
		bus(0, 4'h0, 0);
		chk("ctrl", q, 32'h0000_0140);
		@(negedge clk);
		chk("phy_reset_request", prst_n, 0);
		chk("ready", ready, 0);
		report_and_stop;
	end
endmodule
